// File: dv/flash_torch_led_mode_controller_bench.sv
// flash_torch_led_mode_controller_bench: drives fltc_top over AHB-Lite and its pins.
// assumes shortened counts: timeout step 100, deglitch 20, ramp step 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module flash_torch_led_mode_controller_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        trig, pin_in, pin_out, pin_oe, hot, near, hr_low, boost, ilim;
  logic [4:0]  led;
  logic [3:0]  cmd = 4'h0;
  logic [31:0] rd;
  logic [31:0] rnd = 32'h0001_3987;
  int          fails = 0;
  int          checks_done = 0;
  // register model: contents and writable bits
  int          exp_reg[8];
  int          msk[8] = '{7, 7, 15, 63, 0, 160, 7, 0};
  always #5 hclk = ~hclk;
  fltc_top #(.TO_STEP_CYC(100), .DEGLITCH_CYC(20), .STEP_CYC(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_trigger_in(trig),
    .general_io_pin_one_in(pin_in), .general_io_pin_one_out(pin_out),
    .general_io_pin_one_oe(pin_oe), .over_temp_in(hot), .out_near_in_in(near),
    .headroom_low_in(hr_low), .led_level(led), .boost_select(boost), .ilim_high(ilim));
  fltc_pins pins (.hclk(hclk), .cmd(cmd), .led_level(led), .pin_out(pin_out), .pin_oe(pin_oe),
    .trig(trig), .pin_in(pin_in), .hot(hot), .near(near), .hr_low(hr_low));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin fails++; close_out(); end
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    if (a < 8'h20) exp_reg[a[4:2]] = d & msk[a[4:2]];
  endtask : wr
  task automatic rc(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
    chk(rd, (a < 8'h20) ? exp_reg[a[4:2]] : 32'h0);
  endtask : rc
  task automatic wait_lvl(input logic [4:0] v);
    int n;
    n = 0;
    while (led !== v && n < 1000) begin @(posedge hclk); n++; end
    if (n >= 1000) begin fails++; close_out(); end
    chk({27'h0, led}, {27'h0, v});
  endtask : wait_lvl
  initial begin
    exp_reg = '{0, 0, 15, 63, 0, 0, 0, 0};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) rc(8'(i * 4));
    wr(8'h20, 32'hffff_ffff);
    rc(8'h20);
    wr(8'h0c, 32'h0);
    #1 chk({31'h0, ilim}, 32'h0);
    rnd = lfsr(rnd);
    wr(8'h04, rnd & 7);
    wr(8'h00, 32'h2);
    wait_lvl(5'(rnd[2:0]) + 5'h01);
    exp_reg[7] = 32'h40 | (rnd[2:0] + 1);
    rc(8'h1c);
    wr(8'h00, 32'h0);
    wait_lvl(5'h00);
    rnd = lfsr(rnd);
    wr(8'h08, rnd & 15);
    wr(8'h00, 32'h3);
    wait_lvl(5'h09 + 5'(rnd[3:0]));
    wait_lvl(5'h00);
    // a timed-out flash clears the mode field back to off
    exp_reg[0] = 0;
    exp_reg[4] = 1;
    rc(8'h00);
    rc(8'h10);
    exp_reg[4] = 0;
    rc(8'h10);
    // pulse-cut input made active low, so a low pin cuts the flash
    wr(8'h14, 32'h20);
    wr(8'h0c, 32'h3);
    wr(8'h04, 32'h2);
    cmd <= 4'hb;
    wait_lvl(5'h09 + 5'(rnd[3:0]));
    chk({31'h0, boost}, 32'h1);
    cmd <= 4'h9;
    wait_lvl(5'h03);
    cmd <= 4'hb;
    wait_lvl(5'h09 + 5'(rnd[3:0]));
    cmd <= 4'ha;
    wait_lvl(5'h00);
    // register flash of 400 cycles; a trigger rise at 300 restarts the count
    wr(8'h00, 32'h3);
    repeat (300) @(posedge hclk);
    cmd <= 4'hb;
    repeat (300) @(posedge hclk);
    chk({31'h0, led == 5'h00}, 32'h0);
    cmd <= 4'ha;
    wait_lvl(5'h00);
    ahb(1'b0, 8'h10, 32'h0);
    // end select 1: trigger fall leaves the flash running
    wr(8'h00, 32'h4);
    cmd <= 4'h3;
    repeat (20) @(posedge hclk);
    cmd <= 4'h2;
    repeat (20) @(posedge hclk);
    chk({31'h0, led == 5'h00}, 32'h0);
    wait_lvl(5'h00);
    ahb(1'b0, 8'h10, 32'h0);
    // short over-temperature glitch must not trip
    cmd <= 4'h6;
    repeat (10) @(posedge hclk);
    cmd <= 4'h2;
    wr(8'h00, 32'h2);
    wait_lvl(5'h03);
    cmd <= 4'h6;
    wait_lvl(5'h00);
    cmd <= 4'h2;
    wr(8'h00, 32'h2);
    repeat (40) @(posedge hclk);
    chk({27'h0, led}, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd & 32'h2, 32'h2);
    wr(8'h00, 32'h2);
    wait_lvl(5'h03);
    wr(8'h00, 32'h0);
    wait_lvl(5'h00);
    wr(8'h14, 32'h80);
    wait_lvl(5'h03);
    cmd <= 4'h3;
    wait_lvl(5'h09 + 5'(rnd[3:0]));
    cmd <= 4'h2;
    wait_lvl(5'h00);
    exp_reg[5] = 0;
    rc(8'h14);
    wr(8'h18, 32'h7);
    #1 chk({30'h0, pin_oe, pin_out}, 32'h3);
    exp_reg[6] = 15;
    rc(8'h18);
    close_out();
  end
endmodule : flash_torch_led_mode_controller_bench
`default_nettype wire

// File: dv/fltc_pins.sv
// fltc_pins: far side of the mode controller, i.e. trigger, shared pin, die sensor and output stage.
// assumes the bench sets cmd just after a rising edge; trig, hot and hr_low follow one edge later, pin_in at once.
`timescale 1ns/100ps
`default_nettype none
module fltc_pins (
  input  wire logic       hclk,
  input  wire logic [3:0] cmd,
  input  wire logic [4:0] led_level,
  input  wire logic       pin_out,
  input  wire logic       pin_oe,
  output logic            trig,
  output logic            pin_in,
  output logic            hot,
  output logic            near,
  output logic            hr_low
);
  logic [1:0] on_q;
  initial begin
    trig = 1'b0;
    hot = 1'b0;
    hr_low = 1'b0;
    on_q = 2'h0;
  end
  always @(posedge hclk) begin
    trig <= cmd[0];
    hot <= cmd[2];
    hr_low <= cmd[3];
    on_q <= {on_q[0], led_level != 5'h00};
  end
  // the output only nears the input a while after the source turns on
  assign near = on_q[1];
  // driven pin wins over the far side
  assign pin_in = pin_oe ? pin_out : cmd[1];
endmodule : fltc_pins
`default_nettype wire

// File: dv/fltc_top_sva.sv
// fltc_top_sva: port checks of the flash/torch mode controller.
// assumes single AHB-Lite transfers and STEP_CYC of 4.
`timescale 1ns/100ps
`default_nettype none
module fltc_top_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        headroom_low_in,
  input wire logic [4:0]  led_level,
  input wire logic        boost_select,
  input wire logic        ilim_high
);
  logic rd_req;
  logic wr_req;
  logic wr_dp_q;
  assign rd_req = hsel & htrans[1] & hready & !hwrite;
  assign wr_req = hsel & htrans[1] & hready & hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_dp_q <= 1'b0;
    else wr_dp_q <= wr_req;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  a_write_nowait: assert property (wr_req |=> hreadyout) else $error("write data phase stalled");
  a_level_step: assert property (led_level > $past(led_level) |->
    led_level == $past(led_level) + 5'h01) else $error("level rose by more than one");
  // three quiet cycles after a rise: step interval of four
  a_step_hold: assert property (led_level > $past(led_level) |=>
    !(led_level > $past(led_level)) [*3]) else $error("level rose too soon");
  a_level_cap: assert property (led_level <= 5'h18) else $error("level above top flash");
  a_boost_cause: assert property ($rose(boost_select) |-> $past(headroom_low_in))
    else $error("switching chosen without low headroom");
  // the limit lands at the end of the data phase and is seen one edge later
  a_ilim_cause: assert property ($changed(ilim_high) |-> $past(wr_dp_q))
    else $error("limit select moved without a write");
  c_read: cover property (rd_req);
  c_boost: cover property ($rose(boost_select));
  c_top: cover property (led_level > 5'h08);
endmodule : fltc_top_sva
bind fltc_top fltc_top_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .headroom_low_in(headroom_low_in), .led_level(led_level), .boost_select(boost_select),
  .ilim_high(ilim_high));
`default_nettype wire

// File: logic/fltc_deglitch.sv
// fltc_deglitch: qualifies a raw level that must hold for CYC cycles without a break.
// assumes the raw input is synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none
module fltc_deglitch #(
  parameter int CYC = 25000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic raw,
  output logic      qual
);
  fltc_pkg::fltc_dgl_st_t q, d;

  always_comb begin
    d = q;
    if (!raw) begin
      // any drop restarts the interval
      d.cnt  = 32'h0;
      d.qual = 1'b0;
    end else if (q.cnt == 32'(CYC - 1)) begin
      d.qual = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign qual = q.qual;
endmodule : fltc_deglitch
`default_nettype wire

// File: logic/fltc_ramp.sv
// fltc_ramp: steps the LED level code up toward a target, one code per step interval.
// assumes a target that may change any cycle; zero means off at once.
`timescale 1ns/100ps
`default_nettype none
`include "fltc_map.svh"
module fltc_ramp #(
  parameter int STEP_CYC = `FLTC_STEP_CYC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [4:0] target,
  output logic      [4:0] level
);
  fltc_pkg::fltc_ramp_st_t q, d;

  always_comb begin
    d = q;
    if (target == 5'h00) begin
      d.level = 5'h00;
      d.tmr   = 16'h0000;
    end else if (target < q.level) begin
      // dropping to a lower level is immediate, only rising is paced
      d.level = target;
      d.tmr   = 16'h0000;
    end else if (target > q.level) begin
      if (q.tmr == 16'(STEP_CYC - 1)) begin
        d.tmr   = 16'h0000;
        d.level = q.level + 5'h01;
      end else begin
        d.tmr = q.tmr + 16'h0001;
      end
    end else begin
      d.tmr = 16'h0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.level;
endmodule : fltc_ramp
`default_nettype wire

// File: logic/fltc_top.sv
// fltc_top: mode and sequencing logic of a flash/torch LED driver with an AHB-Lite slave.
// assumes all pin inputs are synchronous to hclk; hresetn stands for the hardware enable.
//
// Operation
// - mode field written 11 starts flash
// - mode field written 10 starts torch
// - rising flash trigger input starts flash regardless of mode field
// - sixteen flash levels from a four-bit flash brightness field
// - flash ramps through all torch then flash levels, one per 32 us
// - eight torch levels, three-bit field, ramp one level per 32 us
// - end select 1: flash ends only at timeout
// - end select 0: trigger low, mode written 00 or timeout ends flash
// - end select 0: trigger rising edge restarts the timeout count
// - any flash end turns LED fully off, even with torch enabled
// - flash end clears mode field to 00
// - five-bit timeout, 32 ms steps, 32 ms to 1024 ms
// - switch current limit select from duration register bit 5
// - thermal trip shuts LED, sets flag, blocks restart until flags read
// - over-temperature qualified for 250 us before latching
// - first near-input charge picks boost if headroom low, else pass
// - switching, once chosen, holds until shutdown and re-enable; here boost clears whenever the state returns to idle
// - pulse-cut active during flash forces torch; release restores flash
// - configuration bit 5 makes the pulse-cut input active low
// - hardware torch bit: pin high gives torch; flash has precedence
// - flash end in hardware torch clears the hardware torch bit
// - general I/O bit 0 makes the pin plain I/O, bits 2:1 set it
// - timeout derived by dividing the block clock
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fltc_map.svh"
module fltc_top #(
  parameter int TO_STEP_CYC  = `FLTC_TO_STEP_CYC,
  parameter int DEGLITCH_CYC = `FLTC_DEGLITCH_CYC,
  parameter int STEP_CYC     = `FLTC_STEP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        flash_trigger_in,
  input  wire logic        general_io_pin_one_in,
  output logic             general_io_pin_one_out,
  output logic             general_io_pin_one_oe,
  input  wire logic        over_temp_in,
  input  wire logic        out_near_in_in,
  input  wire logic        headroom_low_in,
  output logic      [4:0]  led_level,
  output logic             boost_select,
  output logic             ilim_high
);
  fltc_pkg::fltc_top_st_t q, d;

  logic [4:0] target;
  logic       tt_qual;

  // timeout limit in cycles for a five-bit setting: (n+1) steps of the unit
  function automatic logic [31:0] to_limit(input logic [4:0] dur);
    to_limit = 32'((32'(dur) + 32'h1) * 32'(TO_STEP_CYC));
  endfunction : to_limit

  function automatic logic [31:0] rd_mux(input fltc_pkg::fltc_top_st_t s,
                                         input logic                  pin,
                                         input logic [4:0]            lvl);
    rd_mux = 32'h0;
    case (s.addr)
      `FLTC_OFF_ENABLE:    rd_mux = {29'h0, s.fes, s.mode};
      `FLTC_OFF_TORCH_BR:  rd_mux = {29'h0, s.torch_br};
      `FLTC_OFF_FLASH_BR:  rd_mux = {28'h0, s.flash_br};
      `FLTC_OFF_FLASH_DUR: rd_mux = {26'h0, s.ilim, s.dur};
      `FLTC_OFF_FLAGS:     rd_mux = {30'h0, s.tt_flag, s.to_flag};
      `FLTC_OFF_CONFIG1:   rd_mux = {24'h0, s.hwt_en, 1'b0, s.pc_pol, 5'h00};
      `FLTC_OFF_GPIO:      rd_mux = {28'h0, pin, s.gp_lvl, s.gp_dir, s.gp_en};
      `FLTC_OFF_STATUS:    rd_mux = {24'h0, s.state, s.boost, lvl};
      default:             rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  always_comb begin
    logic        acc;
    logic        wr;
    logic        pc_act;
    logic        hwt;
    logic        s_rise;
    logic        s_fall;
    logic        lock;
    logic        flash_req;
    logic        wr_off;
    logic        end_to;
    logic        end_sw;
    logic        set_to;
    logic [1:0]  wmode;
    acc       = 1'b0;
    wr        = 1'b0;
    pc_act    = 1'b0;
    hwt       = 1'b0;
    s_rise    = 1'b0;
    s_fall    = 1'b0;
    lock      = 1'b0;
    flash_req = 1'b0;
    wr_off    = 1'b0;
    end_to    = 1'b0;
    end_sw    = 1'b0;
    set_to    = 1'b0;
    wmode     = 2'h0;
    d         = q;
    d.hresp   = 1'b0;

    // shared pin: plain I/O overrides both pulse-cut and hardware torch
    pc_act = !q.gp_en && !q.hwt_en && (general_io_pin_one_in ^ q.pc_pol);
    hwt    = !q.gp_en && q.hwt_en && general_io_pin_one_in;
    s_rise = flash_trigger_in && !q.strobe_d;
    s_fall = !flash_trigger_in && q.strobe_d;
    d.strobe_d = flash_trigger_in;
    lock   = q.tt_flag;
    wmode  = hwdata[`FLTC_EN_MODE_LSB +: 2];
    wr     = q.wr_pend;
    wr_off = wr && (q.addr == `FLTC_OFF_ENABLE) && (wmode == `FLTC_MODE_OFF);
    flash_req = (q.mode == `FLTC_MODE_FLASH) || s_rise;

    // mode sequencing
    case (q.state)
      fltc_pkg::FLTC_ST_IDLE, fltc_pkg::FLTC_ST_TORCH: begin
        if (lock) begin
          d.state = fltc_pkg::FLTC_ST_IDLE;
        end else if (flash_req) begin
          d.state     = fltc_pkg::FLTC_ST_FLASH;
          d.to_cnt    = 32'h0;
          d.by_strobe = s_rise && (q.mode != `FLTC_MODE_FLASH);
        end else if ((q.mode == `FLTC_MODE_TORCH) || hwt) begin
          d.state = fltc_pkg::FLTC_ST_TORCH;
        end else begin
          d.state = fltc_pkg::FLTC_ST_IDLE;
        end
      end
      fltc_pkg::FLTC_ST_FLASH: begin
        d.to_cnt = q.to_cnt + 32'h1;
        end_to   = q.to_cnt >= (to_limit(q.dur) - 32'h1);
        end_sw   = !q.fes && ((q.by_strobe && s_fall) || wr_off);
        if (lock || end_to || end_sw) begin
          d.state  = fltc_pkg::FLTC_ST_IDLE;
          d.mode   = `FLTC_MODE_OFF;
          d.hwt_en = 1'b0;
          set_to   = end_to;
        end else if (!q.fes && s_rise) begin
          d.to_cnt    = 32'h0;
          d.by_strobe = 1'b1;
        end
      end
      default: begin
        d.state = fltc_pkg::FLTC_ST_IDLE;
      end
    endcase

    // pass or boost: first near-input decides; low headroom later still picks boost, which is then sticky
    if (q.state == fltc_pkg::FLTC_ST_IDLE) begin
      d.boost   = 1'b0;
      d.decided = 1'b0;
    end else if (!q.decided) begin
      if (out_near_in_in) begin
        d.decided = 1'b1;
        d.boost   = headroom_low_in;
      end
    end else if (headroom_low_in) begin
      d.boost = 1'b1;
    end

    // AHB-Lite: writes take no wait, reads take one wait state
    acc = hsel && htrans[1] && hready;
    if (wr) begin
      case (q.addr)
        `FLTC_OFF_ENABLE: begin
          d.mode = wmode;
          d.fes  = hwdata[`FLTC_EN_FES_BIT];
        end
        `FLTC_OFF_TORCH_BR:  d.torch_br = hwdata[2:0];
        `FLTC_OFF_FLASH_BR:  d.flash_br = hwdata[3:0];
        `FLTC_OFF_FLASH_DUR: begin
          d.dur  = hwdata[4:0];
          d.ilim = hwdata[`FLTC_DUR_ILIM_BIT];
        end
        `FLTC_OFF_CONFIG1: begin
          d.pc_pol = hwdata[`FLTC_CFG1_POL_BIT];
          d.hwt_en = hwdata[`FLTC_CFG1_HWT_BIT];
        end
        `FLTC_OFF_GPIO: begin
          d.gp_en  = hwdata[`FLTC_GPIO_EN_BIT];
          d.gp_dir = hwdata[`FLTC_GPIO_DIR_BIT];
          d.gp_lvl = hwdata[`FLTC_GPIO_LVL_BIT];
        end
        default: begin
        end
      endcase
    end
    d.wr_pend = acc && hwrite;
    d.rd_pend = acc && !hwrite;
    if (acc) begin
      d.addr = haddr[7:0];
    end
    if (acc && !hwrite) begin
      d.hready = 1'b0;
    end
    if (q.rd_pend) begin
      d.hrdata = rd_mux(q, general_io_pin_one_in, led_level);
      d.hready = 1'b1;
      if (q.addr == `FLTC_OFF_FLAGS) begin
        d.to_flag = 1'b0;
        d.tt_flag = 1'b0;
      end
    end

    // hardware sets after the read clear, so a coincident event survives
    if (set_to) begin
      d.to_flag = 1'b1;
    end
    if (tt_qual) begin
      d.tt_flag = 1'b1;
    end
  end

  // level target: torch codes 1..8, flash codes 9..24
  always_comb begin
    case (q.state)
      fltc_pkg::FLTC_ST_TORCH: target = `FLTC_LVL_TORCH_BASE + {2'h0, q.torch_br};
      fltc_pkg::FLTC_ST_FLASH: begin
        if (pc_cut_now()) begin
          target = `FLTC_LVL_TORCH_BASE + {2'h0, q.torch_br};
        end else begin
          target = `FLTC_LVL_FLASH_BASE + {1'b0, q.flash_br};
        end
      end
      default: target = 5'h00;
    endcase
  end

  function automatic logic pc_cut_now();
    pc_cut_now = !q.gp_en && !q.hwt_en && (general_io_pin_one_in ^ q.pc_pol);
  endfunction : pc_cut_now

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.state    <= fltc_pkg::FLTC_ST_IDLE;
      q.torch_br <= `FLTC_RST_TORCH_BR;
      q.flash_br <= `FLTC_RST_FLASH_BR;
      q.dur      <= `FLTC_RST_FLASH_DUR;
      q.ilim     <= `FLTC_RST_ILIM;
      q.hready   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // steps through torch and flash codes at the 32 us pace
  fltc_ramp #(
    .STEP_CYC (STEP_CYC)
  ) u_ramp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .target  (target),
    .level   (led_level)
  );

  // noise on ground during boost can hold this off; that is accepted
  fltc_deglitch #(
    .CYC (DEGLITCH_CYC)
  ) u_tt_dgl (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     (over_temp_in),
    .qual    (tt_qual)
  );

  assign hrdata                 = q.hrdata;
  assign hreadyout              = q.hready;
  assign hresp                  = q.hresp;
  assign boost_select           = q.boost;
  assign ilim_high              = q.ilim;
  assign general_io_pin_one_out = q.gp_lvl;
  assign general_io_pin_one_oe  = q.gp_en && q.gp_dir;
endmodule : fltc_top
`default_nettype wire

// File: pkg/fltc_map.svh
// fltc_map.svh: register offsets, field positions, reset values and timing counts
// of the flash/torch LED mode controller. Included by bare name; definitions only.
`ifndef FLTC_MAP_SVH
`define FLTC_MAP_SVH

// register byte offsets on the AHB-Lite slave (one aligned word each)
`define FLTC_OFF_ENABLE      8'h00
`define FLTC_OFF_TORCH_BR    8'h04
`define FLTC_OFF_FLASH_BR    8'h08
`define FLTC_OFF_FLASH_DUR   8'h0c
`define FLTC_OFF_FLAGS       8'h10
`define FLTC_OFF_CONFIG1     8'h14
`define FLTC_OFF_GPIO        8'h18
`define FLTC_OFF_STATUS      8'h1c

// enable register fields
`define FLTC_EN_MODE_LSB     0
`define FLTC_EN_FES_BIT      2
`define FLTC_MODE_OFF        2'h0
`define FLTC_MODE_INDICATOR  2'h1
`define FLTC_MODE_TORCH      2'h2
`define FLTC_MODE_FLASH      2'h3

// flash duration register fields
`define FLTC_DUR_ILIM_BIT    5

// flags register fields
`define FLTC_FLG_TIMEOUT_BIT 0
`define FLTC_FLG_THERMAL_BIT 1

// configuration register 1 fields
`define FLTC_CFG1_POL_BIT    5
`define FLTC_CFG1_HWT_BIT    7

// general I/O register fields
`define FLTC_GPIO_EN_BIT     0
`define FLTC_GPIO_DIR_BIT    1
`define FLTC_GPIO_LVL_BIT    2
`define FLTC_GPIO_IN_BIT     3

// reset values
`define FLTC_RST_TORCH_BR    3'h0
`define FLTC_RST_FLASH_BR    4'hf
`define FLTC_RST_FLASH_DUR   5'h1f
`define FLTC_RST_ILIM        1'h1

// LED level codes: 0 off, 1..8 torch levels, 9..24 flash levels
`define FLTC_LVL_TORCH_BASE  5'h01
`define FLTC_LVL_FLASH_BASE  5'h09

// timing
`define FLTC_CLK_MHZ         100
`define FLTC_STEP_US         32
`define FLTC_STEP_CYC        (`FLTC_STEP_US * `FLTC_CLK_MHZ)
`define FLTC_TO_STEP_MS      32
`define FLTC_TO_STEP_CYC     (`FLTC_TO_STEP_MS * 1000 * `FLTC_CLK_MHZ)
`define FLTC_DEGLITCH_US     250
`define FLTC_DEGLITCH_CYC    (`FLTC_DEGLITCH_US * `FLTC_CLK_MHZ)

`endif

// File: pkg/fltc_pkg.sv
// fltc_pkg: types of the flash/torch LED mode controller.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fltc_pkg;

  typedef enum logic [1:0] {
    FLTC_ST_IDLE  = 2'b00,
    FLTC_ST_TORCH = 2'b01,
    FLTC_ST_FLASH = 2'b10
  } fltc_state_t;

  typedef struct packed {
    logic [4:0]  level;
    logic [15:0] tmr;
  } fltc_ramp_st_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        qual;
  } fltc_dgl_st_t;

  typedef struct packed {
    fltc_state_t state;
    logic [1:0]  mode;
    logic        fes;
    logic [2:0]  torch_br;
    logic [3:0]  flash_br;
    logic [4:0]  dur;
    logic        ilim;
    logic        to_flag;
    logic        tt_flag;
    logic        pc_pol;
    logic        hwt_en;
    logic        gp_en;
    logic        gp_dir;
    logic        gp_lvl;
    logic        strobe_d;
    logic        by_strobe;
    logic [31:0] to_cnt;
    logic        boost;
    logic        decided;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
  } fltc_top_st_t;

endpackage : fltc_pkg
`default_nettype wire
